// ---- rtl/apf_pkg.sv ----
// Purpose: Shared constants and types for the frame-sync pin block.
// Assumes: APB slave with 32-bit data and one aligned word per register.
// Notes:   Register layouts are packed structs; high bits first.
package apf_pkg;

    localparam int APF_AW = 8;
    localparam int APF_DW = 32;

    // Register byte offsets.
    localparam logic [APF_AW-1:0] APF_OFS_CCTRL = 8'h00;
    localparam logic [APF_AW-1:0] APF_OFS_RXCLK = 8'h04;
    localparam logic [APF_AW-1:0] APF_OFS_TXCLK = 8'h08;
    localparam logic [APF_AW-1:0] APF_OFS_STAT  = 8'h0c;
    localparam logic [APF_AW-1:0] APF_OFS_GPIO  = 8'h10;

    // General-purpose mode of one pin; code 2'b11 acts as disconnected.
    typedef enum logic [1:0] {
        APF_GP_DISC = 2'b00,
        APF_GP_IN   = 2'b01,
        APF_GP_OUT  = 2'b10
    } apf_gpio_mode_type;

    // Common control register, bit 4 first, bit 0 last.
    typedef struct packed {
        logic portEnable;
        logic networkMode;
        logic outputFlagOne;
        logic txExtBufferEnableSelect;
        logic syncModeSelect;
    } apf_common_ctrl_type;

    // General-purpose control register.
    typedef struct packed {
        logic              txGpioOut;
        logic              rxGpioOut;
        apf_gpio_mode_type txGpioMode;
        apf_gpio_mode_type rxGpioMode;
    } apf_gpio_ctrl_type;

    // Common status register.
    typedef struct packed {
        logic txPinLevel;
        logic rxPinLevel;
        logic inputFlagOne;
    } apf_status_type;

    localparam int APF_CCTRL_W = $bits(apf_common_ctrl_type);
    localparam int APF_GPIO_W  = $bits(apf_gpio_ctrl_type);
    localparam int APF_STAT_W  = $bits(apf_status_type);
    localparam int APF_DIR_W   = 1;

    localparam apf_common_ctrl_type APF_CCTRL_RESET = '0;
    localparam apf_gpio_ctrl_type   APF_GPIO_RESET  = '0;
    localparam logic                APF_DIR_RESET   = 1'b0;

    // One two-way pin as driven by the block; oe_b low means driving.
    typedef struct packed {
        logic dout;
        logic oe_b;
    } apf_pad_type;

    localparam apf_pad_type APF_PAD_RESET = '{dout: 1'b0, oe_b: 1'b1};

    // APB request from the master.
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [APF_AW-1:0] paddr;
        logic [APF_DW-1:0] pwdata;
    } apf_apb_req_type;

    // APB answer to the master.
    typedef struct packed {
        logic              pready;
        logic              pslverr;
        logic [APF_DW-1:0] prdata;
    } apf_apb_rsp_type;

endpackage

// ---- rtl/apf_pin_sync.sv ----
// Purpose: Three-stage pin synchroniser with filtered level and rise pulse.
// Assumes: Pin is asynchronous to clock.
// Notes:   A change counts once the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module apf_pin_sync (
    input  wire logic clock, // System clock.
    input  wire logic rst_b, // Asynchronous reset, active low.
    input  wire logic pin,   // Raw pin level.
    output logic      level, // Filtered level.
    output logic      rise   // One-cycle pulse on a rising change.
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic rise;
    } apf_sync_state_type;

    apf_sync_state_type st;
    apf_sync_state_type next_st;

    // Stage one feeds stage two only; the filter reads stages two and three.
    always_comb begin
        next_st      = st;
        next_st.s1   = pin;
        next_st.s2   = st.s1;
        next_st.s3   = st.s2;
        next_st.rise = 1'b0;
        if (st.s2 == st.s3) begin
            next_st.level = st.s3;
            next_st.rise  = st.s3 & ~st.level;
        end
    end

    // State register.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.level;
    assign rise  = st.rise;
endmodule
`default_nettype wire

// ---- rtl/apf_frame_sync_pins.sv ----
// Purpose: Frame-sync pin logic of the second serial audio port.
// Assumes: APB register access; datapath signals share clock.
// Notes:   Pins leave reset as disconnected general-purpose lines.
//
// Notes on behaviour
// - Async mode: rx pin is receivers' frame sync.
// - Sync, buffer select 0: rx pin is flag one.
// - Sync, select 1, rx dir 1: drive buffer enable.
// - Flag direction follows rx frame-sync direction bit.
// - Output flag pin shows output flag one.
// - Output flag updates at frame sync or slot.
// - Input flag captured at frame sync or slot.
// - Sync mode: tx pin frames both directions; receivers get none in flag mode.
// - Async mode: tx pin frames transmitters only.
// - Tx pin direction follows tx direction bit.
// - GPIO: each pin input, output or disconnected.
// - Reset leaves pins disconnected GPIO.
// - Tx bit clock clocks receivers only in sync.
`timescale 1ns/1ps
`default_nettype none
module apf_frame_sync_pins
    import apf_pkg::*;
(
    input  wire logic                     clock,       // 100 MHz clock.
    input  wire logic                     rst_b,       // Async reset, low.
    input  wire apf_pkg::apf_apb_req_type apbReq,      // APB request.
    output var  apf_pkg::apf_apb_rsp_type apbRsp,      // APB answer.
    input  wire logic                     rxFsPinIn,   // Rx frame-sync pin.
    output var  apf_pkg::apf_pad_type     rxFsPad,     // Rx pin drive.
    input  wire logic                     txFsPinIn,   // Tx frame-sync pin.
    output var  apf_pkg::apf_pad_type     txFsPad,     // Tx pin drive.
    input  wire logic                     txBitClkIn,  // Tx bit clock pin.
    input  wire logic                     rxBitTickIn, // Rx bit clock edge.
    input  wire logic                     rxFsInt,     // Rx frame sync made.
    input  wire logic                     txFsInt,     // Tx frame sync made.
    input  wire logic                     slotStrobe,  // Slot start pulse.
    input  wire logic                     txDataOn,    // Tx data active.
    input  wire logic                     rxEnable,    // Receivers enabled.
    input  wire logic                     txEnable,    // Transmitters on.
    output logic                          rxFrameSync, // Rx frame sync used.
    output logic                          txFrameSync, // Tx frame sync used.
    output logic                          rxBitTick,   // Rx bit clock edge.
    output logic                          txBitTick    // Tx bit clock edge.
);

    ////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        apf_common_ctrl_type cctrl;
        logic                rxDir;
        logic                txDir;
        apf_gpio_ctrl_type   gpio;
        logic                inputFlagOne;
        logic                flagOut;
        logic                txFsPrev;
        apf_pad_type         rxPad;
        apf_pad_type         txPad;
        logic                rxFs;
        logic                txFs;
        logic                rxTick;
        logic                txTick;
        logic [APF_DW-1:0]   prdata;
        logic                pslverr;
    } apf_state_type;

    localparam apf_state_type ST_RESET = '{
        cctrl:        APF_CCTRL_RESET,
        rxDir:        APF_DIR_RESET,
        txDir:        APF_DIR_RESET,
        gpio:         APF_GPIO_RESET,
        inputFlagOne: 1'b0,
        flagOut:      1'b0,
        txFsPrev:     1'b0,
        rxPad:        APF_PAD_RESET,
        txPad:        APF_PAD_RESET,
        rxFs:         1'b0,
        txFs:         1'b0,
        rxTick:       1'b0,
        txTick:       1'b0,
        prdata:       '0,
        pslverr:      1'b0
    };

    apf_state_type st;
    apf_state_type next_st;

    // True for an address that holds a register.
    function automatic logic isMapped(input logic [APF_AW-1:0] a);
        return (a == APF_OFS_CCTRL) || (a == APF_OFS_RXCLK) ||
               (a == APF_OFS_TXCLK) || (a == APF_OFS_STAT) ||
               (a == APF_OFS_GPIO);
    endfunction

    // Pad value for a pin in general-purpose mode.
    function automatic apf_pad_type gpioPad(input apf_gpio_mode_type m,
                                            input logic              v);
        apf_pad_type p;
        p = APF_PAD_RESET;
        if (m == APF_GP_OUT) begin
            p = '{dout: v, oe_b: 1'b0};
        end
        return p;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic rxLevel;
    logic txLevel;
    logic sckRise;

    apf_pin_sync u_rx_sync (
        .clock (clock),
        .rst_b (rst_b),
        .pin   (rxFsPinIn),
        .level (rxLevel),
        .rise  ()
    );

    apf_pin_sync u_tx_sync (
        .clock (clock),
        .rst_b (rst_b),
        .pin   (txFsPinIn),
        .level (txLevel),
        .rise  ()
    );

    apf_pin_sync u_sck_sync (
        .clock (clock),
        .rst_b (rst_b),
        .pin   (txBitClkIn),
        .level (),
        .rise  (sckRise)
    );

    ////////////////////////////////////////////////////////////////////////
    // Mode decoding.

    logic portEn;
    logic syncMode;
    logic flagMode;
    logic txFsSel;
    logic rxFsSel;
    logic flagEvent;
    logic apbSetup;
    logic apbWrite;
    apf_status_type status;

    // Mode terms and selected frame syncs; external syncs arrive through
    // the pin synchronisers on clock, so no realignment is done here.
    assign portEn   = st.cctrl.portEnable;
    assign syncMode = st.cctrl.syncModeSelect;
    assign flagMode = portEn & syncMode & ~st.cctrl.txExtBufferEnableSelect;
    assign txFsSel  = st.txDir ? txFsInt : txLevel;
    assign rxFsSel  = syncMode ? txFsSel :
                      (st.rxDir ? rxFsInt : rxLevel);
    // Flag timing follows frame sync, or each slot in network mode.
    assign flagEvent = flagMode &
                       (st.cctrl.networkMode ? slotStrobe :
                        (txFsSel & ~st.txFsPrev));
    assign apbSetup = apbReq.psel & ~apbReq.penable;
    assign apbWrite = apbReq.psel & apbReq.penable & apbReq.pwrite;
    assign status   = '{txPinLevel: txLevel, rxPinLevel: rxLevel,
                        inputFlagOne: st.inputFlagOne};

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    always_comb begin
        next_st          = st;
        next_st.txFsPrev = txFsSel;

        // Read data and error are prepared in the setup cycle.
        if (apbSetup) begin
            next_st.prdata  = '0;
            next_st.pslverr = ~isMapped(apbReq.paddr);
            if (!apbReq.pwrite) begin
                unique case (apbReq.paddr)
                    APF_OFS_CCTRL: next_st.prdata[APF_CCTRL_W-1:0] = st.cctrl;
                    APF_OFS_RXCLK: next_st.prdata[APF_DIR_W-1:0]   = st.rxDir;
                    APF_OFS_TXCLK: next_st.prdata[APF_DIR_W-1:0]   = st.txDir;
                    APF_OFS_STAT:  next_st.prdata[APF_STAT_W-1:0]  = status;
                    APF_OFS_GPIO:  next_st.prdata[APF_GPIO_W-1:0]  = st.gpio;
                    default:       next_st.prdata = '0;
                endcase
            end
        end

        // Writes take effect in the access cycle; status is read-only.
        if (apbWrite) begin
            unique case (apbReq.paddr)
                APF_OFS_CCTRL: next_st.cctrl = apf_common_ctrl_type'(
                    apbReq.pwdata[APF_CCTRL_W-1:0]);
                APF_OFS_RXCLK: next_st.rxDir = apbReq.pwdata[APF_DIR_W-1];
                APF_OFS_TXCLK: next_st.txDir = apbReq.pwdata[APF_DIR_W-1];
                APF_OFS_GPIO:  next_st.gpio = apf_gpio_ctrl_type'(
                    apbReq.pwdata[APF_GPIO_W-1:0]);
                default: next_st.cctrl = st.cctrl;
            endcase
        end

        // Flag values move only at frame sync or slot.
        if (flagEvent) begin
            next_st.flagOut = st.cctrl.outputFlagOne;
            if (!st.rxDir) begin
                next_st.inputFlagOne = rxLevel;
            end
        end

        // Rx pin drive by mode.
        if (!portEn) begin
            next_st.rxPad = gpioPad(st.gpio.rxGpioMode,
                                    st.gpio.rxGpioOut);
        end else if (!st.rxDir) begin
            next_st.rxPad = APF_PAD_RESET;
        end else if (!syncMode) begin
            next_st.rxPad = '{dout: rxFsInt, oe_b: 1'b0};
        end else if (!st.cctrl.txExtBufferEnableSelect) begin
            next_st.rxPad = '{dout: st.flagOut, oe_b: 1'b0};
        end else begin
            next_st.rxPad = '{dout: txDataOn, oe_b: 1'b0};
        end

        // Tx pin drive by mode.
        if (!portEn) begin
            next_st.txPad = gpioPad(st.gpio.txGpioMode,
                                    st.gpio.txGpioOut);
        end else if (st.txDir) begin
            next_st.txPad = '{dout: txFsInt, oe_b: 1'b0};
        end else begin
            next_st.txPad = APF_PAD_RESET;
        end

        // Frame syncs and bit clock edges delivered to the datapath.
        next_st.txFs   = portEn & txFsSel;
        next_st.rxFs   = portEn & ~flagMode & rxFsSel;
        next_st.txTick = portEn & txEnable & sckRise;
        next_st.rxTick = portEn & rxEnable &
                         (syncMode ? sckRise : rxBitTickIn);
    end

    // State register; reset gives disconnected pins.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign apbRsp = '{pready: 1'b1, pslverr: st.pslverr, prdata: st.prdata};
    assign rxFsPad     = st.rxPad;
    assign txFsPad     = st.txPad;
    assign rxFrameSync = st.rxFs;
    assign txFrameSync = st.txFs;
    assign rxBitTick   = st.rxTick;
    assign txBitTick   = st.txTick;

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    a_async_rx_fs: assert property (
        portEn && !syncMode && !st.rxDir |=> rxFrameSync == $past(rxLevel))
        else $error("Rx frame sync does not follow rx pin.");

    a_rx_flag_out: assert property (
        flagMode && st.rxDir |=> !rxFsPad.oe_b &&
                                 rxFsPad.dout == $past(st.flagOut))
        else $error("Rx pin does not drive output flag.");

    a_buf_enable: assert property (
        portEn && syncMode && st.cctrl.txExtBufferEnableSelect &&
        st.rxDir |=> !rxFsPad.oe_b && rxFsPad.dout == $past(txDataOn))
        else $error("Rx pin does not drive buffer enable.");

    a_flag_dir_in: assert property (
        flagMode && !st.rxDir |=> rxFsPad.oe_b)
        else $error("Input flag pin is being driven.");

    a_flag_update: assert property (
        flagEvent ##1 (!flagEvent)[*2] |->
        st.flagOut == $past(st.cctrl.outputFlagOne, 2) && $stable(st.flagOut))
        else $error("Output flag not updated at event.");

    a_flag_hold: assert property (
        !flagEvent |=> st.flagOut == $past(st.flagOut))
        else $error("Output flag moved without event.");

    a_in_flag_cap: assert property (
        flagEvent && !st.rxDir |=> st.inputFlagOne == $past(rxLevel))
        else $error("Input flag not captured.");

    a_sync_rx_fs: assert property (
        portEn && syncMode && !flagMode |=> rxFrameSync == $past(txFsSel))
        else $error("Rx frame sync not taken from tx pin.");

    a_tx_fs_path: assert property (
        portEn |=> txFrameSync == $past(st.txDir ? txFsInt : txLevel))
        else $error("Tx frame sync source wrong.");

    a_tx_pin_dir: assert property (
        portEn |=> txFsPad.oe_b == !$past(st.txDir))
        else $error("Tx pin direction wrong.");

    a_gpio_disc: assert property (
        !portEn && st.gpio.rxGpioMode != APF_GP_OUT |=> rxFsPad.oe_b)
        else $error("Disconnected rx line is driven.");

    a_reset_disc: assert property (
        $rose(rst_b) |-> rxFsPad.oe_b && txFsPad.oe_b)
        else $error("Pin driven after reset.");

    a_rx_tick_src: assert property (
        rxBitTick |-> $past(portEn && rxEnable &&
                            (syncMode ? sckRise : rxBitTickIn)))
        else $error("Rx bit tick from wrong clock.");

endmodule
`default_nettype wire

// ---- test/apf_codec_model.sv ----
// Purpose: Far-side codec model for the frame-sync pins.
// Assumes: Each pin has a pull-down; the block's pad drive wins.
// Notes:   The bit clock stands low between bursts.
`timescale 1ns/1ps
`default_nettype none
module apf_codec_model
    import apf_pkg::*;
(
    input  wire apf_pkg::apf_pad_type rxFsPad, // Block rx pad drive.
    input  wire apf_pkg::apf_pad_type txFsPad, // Block tx pad drive.
    input  wire logic                 rxDrive, // Codec drives rx pin.
    input  wire logic                 rxLevel, // Codec rx frame level.
    input  wire logic                 txDrive, // Codec drives tx pin.
    input  wire logic                 txLevel, // Codec tx frame level.
    input  wire logic                 runClk,  // Bit clock burst on.
    output logic                      rxFsPin, // Rx pin wire level.
    output logic                      txFsPin, // Tx pin wire level.
    output logic                      bitClk   // Tx bit clock pin.
);
    import apf_pkg::*;
    ////////////////////////////////////////////////////////////////////
    // Wire level: block drive, else codec frame level, else pull-down.
    assign rxFsPin = !rxFsPad.oe_b ? rxFsPad.dout
                   : (rxDrive ? rxLevel : 1'b0);
    assign txFsPin = !txFsPad.oe_b ? txFsPad.dout
                   : (txDrive ? txLevel : 1'b0);
    // Bit clock bursts of 160 ns period with a phase unrelated to clock.
    always begin
        bitClk = 1'b0;
        wait (runClk);
        #37;
        while (runClk) begin
            bitClk = 1'b1;
            #80;
            bitClk = 1'b0;
            #80;
        end
    end
endmodule
`default_nettype wire

// ---- test/apf_frame_sync_pins_test.sv ----
// Purpose: Self-checking bench for the frame-sync pin block.
// Assumes: APB slave answers whenever pready is high.
// Notes:   Fixed waits cover the pin synchroniser and pad latency.
`timescale 1ns/1ps
`default_nettype none
module apf_frame_sync_pins_test;
    import apf_pkg::*;
    logic            clock = 1'b0;
    logic            rst_b = 1'b0;
    apf_apb_req_type apbReq = '0;
    apf_apb_rsp_type apbRsp;
    apf_pad_type     rxFsPad, txFsPad;
    logic            rxFsPinIn, txFsPinIn, txBitClkIn;
    logic            rxFrameSync, txFrameSync, rxBitTick, txBitTick;
    logic            rxBitTickIn = 1'b0, rxFsInt = 1'b0, txFsInt = 1'b0;
    logic            slotStrobe = 1'b0, txDataOn = 1'b0;
    logic            rxEnable = 1'b1, txEnable = 1'b1, runClk = 1'b0;
    logic            rxDrive = 1'b0, rxLevel = 1'b0;
    logic            txDrive = 1'b0, txLevel = 1'b0;
    logic [31:0]     d;
    logic            e;
    int              errors = 0;
    int              comparisons = 0;
    ////////////////////////////////////////////////////////////////////
    // Clock of 100 MHz.
    always #5 clock = ~clock;
    apf_frame_sync_pins dut (.clock(clock), .rst_b(rst_b),
        .apbReq(apbReq), .apbRsp(apbRsp), .rxFsPinIn(rxFsPinIn),
        .rxFsPad(rxFsPad), .txFsPinIn(txFsPinIn), .txFsPad(txFsPad),
        .txBitClkIn(txBitClkIn), .rxBitTickIn(rxBitTickIn),
        .rxFsInt(rxFsInt), .txFsInt(txFsInt), .slotStrobe(slotStrobe),
        .txDataOn(txDataOn), .rxEnable(rxEnable), .txEnable(txEnable),
        .rxFrameSync(rxFrameSync), .txFrameSync(txFrameSync),
        .rxBitTick(rxBitTick), .txBitTick(txBitTick));
    apf_codec_model codec (.rxFsPad(rxFsPad), .txFsPad(txFsPad),
        .rxDrive(rxDrive), .rxLevel(rxLevel), .txDrive(txDrive),
        .txLevel(txLevel), .runClk(runClk), .rxFsPin(rxFsPinIn),
        .txFsPin(txFsPinIn), .bitClk(txBitClkIn));
    ////////////////////////////////////////////////////////////////////
    // Compares one value and reports a mismatch.
    task automatic check(input string n, input logic [31:0] s,
                         input logic [31:0] x);
        comparisons++;
        if (s !== x) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask
    // One APB transfer; entered just after a rising edge.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
                    pwdata: wd};
        @(posedge clock);
        apbReq.penable <= 1'b1;
        @(posedge clock);
        while (apbRsp.pready !== 1'b1) @(posedge clock);
        d = apbRsp.prdata;
        e = apbRsp.pslverr;
        apbReq <= '0;
        @(posedge clock);
    endtask
    task automatic setup(input logic [4:0] c, input logic rd, td);
        apb(1'b1, APF_OFS_CCTRL, {27'h0, c});
        apb(1'b1, APF_OFS_RXCLK, {31'h0, rd});
        apb(1'b1, APF_OFS_TXCLK, {31'h0, td});
    endtask
    task automatic settle();
        repeat (8) @(posedge clock);
    endtask
    task automatic pulse_slot();
        slotStrobe <= 1'b1;
        @(posedge clock);
        slotStrobe <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////
    // Reset values, an unmapped place and the read-only status word.
    task automatic t_regs();
        check("rx pad reset", rxFsPad, APF_PAD_RESET);
        check("tx pad reset", txFsPad, APF_PAD_RESET);
        rst_b <= 1'b1;
        @(posedge clock);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            check("reg reset", d, 32'h0);
            check("reg reset err", e, 1'b0);
        end
        apb(1'b1, APF_OFS_STAT, 32'h7);
        apb(1'b0, APF_OFS_STAT, 32'h0);
        check("status read-only", d, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        check("unmapped err", e, 1'b1);
        check("unmapped data", d, 32'h0);
    endtask
    // General-purpose modes of both pins.
    task automatic t_gpio();
        txDrive <= 1'b1;
        txLevel <= 1'b1;
        apb(1'b1, APF_OFS_GPIO, 32'h16);
        settle();
        check("rx gp out", rxFsPad, 2'b10);
        check("tx gp in", txFsPad.oe_b, 1'b1);
        apb(1'b0, APF_OFS_STAT, 32'h0);
        check("tx gp level", d[2], 1'b1);
        check("rx gp level", d[1], 1'b1);
        apb(1'b1, APF_OFS_GPIO, 32'h13);
        settle();
        check("rx gp off", rxFsPad.oe_b, 1'b1);
        apb(1'b1, APF_OFS_GPIO, 32'h28);
        settle();
        check("tx gp out", txFsPad, 2'b10);
        apb(1'b1, APF_OFS_GPIO, 32'h0);
    endtask
    // Asynchronous mode with both directions of both pins.
    task automatic t_async();
        setup(5'h10, 1'b0, 1'b0);
        rxDrive <= 1'b1;
        rxLevel <= 1'b1;
        txLevel <= 1'b0;
        settle();
        check("rx fs in", rxFrameSync, 1'b1);
        check("tx fs in", txFrameSync, 1'b0);
        check("tx pad in", txFsPad.oe_b, 1'b1);
        rxLevel <= 1'b0;
        txLevel <= 1'b1;
        settle();
        check("rx fs alone", rxFrameSync, 1'b0);
        check("tx fs alone", txFrameSync, 1'b1);
        setup(5'h10, 1'b1, 1'b1);
        {rxDrive, txDrive, rxFsInt, txFsInt} <= 4'b0001;
        settle();
        check("rx pad out", rxFsPad, 2'b00);
        check("tx pad out", txFsPad, 2'b10);
        check("tx fs out", txFrameSync, 1'b1);
    endtask
    // Synchronous mode driving the external buffer enable.
    task automatic t_buffer();
        setup(5'h13, 1'b1, 1'b0);
        {txDrive, txLevel, txDataOn} <= 3'b111;
        settle();
        check("sync rx fs", rxFrameSync, 1'b1);
        check("buf pad on", rxFsPad, 2'b10);
        {txLevel, txDataOn} <= 2'b00;
        settle();
        check("sync rx fs low", rxFrameSync, 1'b0);
        check("buf pad off", rxFsPad, 2'b00);
    endtask
    // Output flag timed by frame sync, then by slot.
    task automatic t_flag_out();
        {txDrive, txFsInt} <= 2'b00;
        setup(5'h15, 1'b1, 1'b1);
        settle();
        check("flag waits", rxFsPad, 2'b00);
        txFsInt <= 1'b1;
        settle();
        check("flag at fs", rxFsPad, 2'b10);
        apb(1'b1, APF_OFS_CCTRL, 32'h19);
        settle();
        check("flag holds", rxFsPad, 2'b10);
        pulse_slot();
        settle();
        check("flag at slot", rxFsPad, 2'b00);
    endtask
    // Input flag captured at frame sync, then at slot.
    task automatic t_flag_in();
        txFsInt <= 1'b0;
        {rxDrive, rxLevel} <= 2'b11;
        setup(5'h11, 1'b0, 1'b1);
        settle();
        check("flag in pad", rxFsPad.oe_b, 1'b1);
        txFsInt <= 1'b1;
        settle();
        apb(1'b0, APF_OFS_STAT, 32'h0);
        check("in flag fs", d[0], 1'b1);
        apb(1'b1, APF_OFS_CCTRL, 32'h19);
        rxLevel <= 1'b0;
        settle();
        apb(1'b0, APF_OFS_STAT, 32'h0);
        check("in flag holds", d[0], 1'b1);
        pulse_slot();
        settle();
        apb(1'b0, APF_OFS_STAT, 32'h0);
        check("in flag slot", d[0], 1'b0);
    endtask
    // Bit-clock burst of eight periods; counts the tick pulses.
    task automatic burst(input logic [4:0] c, input logic rxOn,
                         input logic [7:0] rxExp);
        logic [7:0] rxN;
        logic [7:0] txN;
        setup(c, 1'b0, 1'b0);
        rxEnable <= rxOn;
        rxN = 8'h00;
        txN = 8'h00;
        runClk <= 1'b1;
        for (int i = 0; i < 160; i++) begin
            @(posedge clock);
            rxN = rxN + 8'(rxBitTick);
            txN = txN + 8'(txBitTick);
            if (i == 127) runClk <= 1'b0;
            rxBitTickIn <= (i % 40 == 10);
        end
        check("tx ticks", txN, 8'h08);
        check("rx ticks", rxN, rxExp);
    endtask
    ////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Main sequence.
    initial begin
        repeat (5) @(posedge clock);
        t_regs();
        t_gpio();
        t_async();
        t_buffer();
        t_flag_out();
        t_flag_in();
        burst(5'h13, 1'b1, 8'h08);
        burst(5'h10, 1'b1, 8'h04);
        burst(5'h13, 1'b0, 8'h00);
        complete_run();
    end
    // Watchdog against a hang.
    initial begin
        repeat (5000) @(posedge clock);
        errors++;
        complete_run();
    end
endmodule
`default_nettype wire
